// ### design/pfi_pkg.sv
// Package with register map, field positions, reset values and carrier types.
package pfi_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_TIMER = 8'h08;
  localparam logic [7:0] ADDR_FLAGS_TWO = 8'h10;
  localparam logic [7:0] ADDR_FLAGS_ONE = 8'h14;
  localparam logic [7:0] ADDR_ENABLE_ONE = 8'h18;
  localparam logic [7:0] ADDR_ENABLE_TWO = 8'h1C;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_WIDE_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;

  // ==========================================================================
  // Bit positions of the first flag register
  localparam int FO_TIMER = 4;
  localparam int FO_CAP2 = 3;
  localparam int FO_CAP1 = 2;
  localparam int FO_TX1 = 1;
  localparam int FO_RX1 = 0;

  // ==========================================================================
  // Bit positions of the second flag register
  localparam int FT_SYNC = 7;
  localparam int FT_BCL = 6;
  localparam int FT_CONV = 5;
  localparam int FT_UNUSED = 4;
  localparam int FT_CAP4 = 3;
  localparam int FT_CAP3 = 2;
  localparam int FT_TX2 = 1;
  localparam int FT_RX2 = 0;

  // ==========================================================================
  // Reset values and timing
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [15:0] RST_PERIOD = 16'h00FF;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic RST_FLAG = 1'b0;
  localparam logic RST_TX_EMPTY = 1'b1;
  localparam logic RST_RX_FULL = 1'b0;
  localparam logic [15:0] TIMER_TICK_DIV = 16'h0004;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic xfer_done;
    logic start_done;
    logic restart_done;
    logic ack_done;
    logic start_idle;
    logic stop_idle;
  } pfi_sync_events_t;

  typedef struct packed {
    logic one_tx_empty;
    logic one_rx_full;
    logic two_tx_empty;
    logic two_rx_full;
  } pfi_serial_status_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01
  } pfi_apb_state_t;

endpackage : pfi_pkg

// ### design/pfi_flag_cell.sv
// One sticky event flag with write-one-to-clear, where a set beats a clear.
module pfi_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set,
  input wire logic clear,
  output logic flag
);

  logic next_flag;

  // ==========================================================================
  // Next value
  always_comb begin
    next_flag = set | (flag & ~clear);
  end

  // ==========================================================================
  // Register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= RESET_VAL;
    end else begin
      flag <= next_flag;
    end
  end

endmodule : pfi_flag_cell

// ### design/pfi_flags.sv
// Peripheral interrupt flag block with APB register access and one interrupt.
//
// Functional notes
// [R1] Byte mode: timer wraps at period, sets flag.
// [R2] Wide mode: timer pair wraps at period pair.
// [R3] Second capture edge sets its flag.
// [R4] First capture edge sets its flag.
// [R5] First transmit flag mirrors buffer empty level.
// [R6] First receive flag mirrors buffer full level.
// [R7] Software clears sync port flag before return.
// [R8] Sync port events set the sync flag.
// [R9] Conversion done sets the converter flag.
// [R10] Second receive flag mirrors buffer full level.
// [R11] Second flag register at 10h, fixed order.
// [R12] Timer enable gates request, never the flag.
// [R13] Collision sets its flag; bit four reads zero.
//
// The implementer's own choice: register access over APB.
module pfi_flags #(
  parameter logic [15:0] TICK_DIV = pfi_pkg::TIMER_TICK_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_one_pin,
  input wire logic capture_two_pin,
  input wire logic capture_three_pin,
  input wire logic capture_four_pin,
  input wire pfi_pkg::pfi_sync_events_t sync_events,
  input wire logic bus_collision_event,
  input wire logic converter_done_event,
  input wire pfi_pkg::pfi_serial_status_t serial_status,
  output logic irq
);
  import pfi_pkg::*;

  pfi_apb_state_t state;
  pfi_apb_state_t next_state;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic setup;
  logic wr_en;
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [15:0] period;
  logic [15:0] next_period;
  logic [7:0] enable_one;
  logic [7:0] next_enable_one;
  logic [7:0] enable_two;
  logic [7:0] next_enable_two;
  logic [15:0] tick_cnt;
  logic [15:0] next_tick_cnt;
  logic tick;
  logic [7:0] timer_one;
  logic [7:0] next_timer_one;
  logic [7:0] timer_two;
  logic [7:0] next_timer_two;
  logic timer_roll;
  logic [3:0] cap_prev;
  logic [3:0] cap_rise;
  pfi_serial_status_t serial_q;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] sticky;
  logic [7:0] flags_one_view;
  logic [7:0] flags_two_view;
  logic next_irq;
  logic mapped;
  logic [7:0] rd_val;

  // ==========================================================================
  // APB slave: one access cycle, answer prepared in the setup cycle
  assign setup = (state == ST_IDLE) && psel && !penable;
  assign wr_en = (state == ST_ACCESS) && psel && penable && pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_val = 8'h00;
    case (paddr)
      ADDR_CTRL: rd_val = ctrl;
      ADDR_PERIOD: rd_val = period[7:0];
      ADDR_TIMER: rd_val = timer_one;
      // [R11] Register decode order
      ADDR_FLAGS_TWO: rd_val = flags_two_view;
      ADDR_FLAGS_ONE: rd_val = flags_one_view;
      ADDR_ENABLE_ONE: rd_val = enable_one;
      ADDR_ENABLE_TWO: rd_val = enable_two;
      default: mapped = 1'b0;
    endcase
    next_state = setup ? ST_ACCESS : ST_IDLE;
    next_pready = setup;
    next_pslverr = setup && !mapped;
    next_prdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      next_prdata[7:0] = rd_val;
      // Upper period and timer bytes share the word so a wide read is atomic.
      if (paddr == ADDR_PERIOD) begin
        next_prdata[15:8] = period[15:8];
      end
      if (paddr == ADDR_TIMER) begin
        next_prdata[15:8] = timer_two;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ==========================================================================
  // Software registers
  always_comb begin
    next_ctrl = ctrl;
    next_period = period;
    next_enable_one = enable_one;
    next_enable_two = enable_two;
    if (wr_en) begin
      case (paddr)
        ADDR_CTRL: next_ctrl = pwdata[7:0];
        ADDR_PERIOD: next_period = pwdata[15:0];
        ADDR_ENABLE_ONE: next_enable_one = pwdata[7:0];
        ADDR_ENABLE_TWO: next_enable_two = pwdata[7:0] & ~(8'h01 << FT_UNUSED);
        default: next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= RST_CTRL;
      period <= RST_PERIOD;
      enable_one <= RST_ENABLE;
      enable_two <= RST_ENABLE;
    end else begin
      ctrl <= next_ctrl;
      period <= next_period;
      enable_one <= next_enable_one;
      enable_two <= next_enable_two;
    end
  end

  // ==========================================================================
  // Timer tick divider and timer pair
  assign tick = (tick_cnt == TICK_DIV - 16'h0001);

  always_comb begin
    next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
    next_timer_one = timer_one;
    next_timer_two = timer_two;
    timer_roll = 1'b0;
    if (ctrl[CTRL_RUN_BIT] && tick) begin
      if (ctrl[CTRL_WIDE_BIT]) begin
        // [R2] Wide pair rollover
        if ({timer_two, timer_one} == period) begin
          {next_timer_two, next_timer_one} = 16'h0000;
          timer_roll = 1'b1;
        end else begin
          {next_timer_two, next_timer_one} = {timer_two, timer_one} + 16'h0001;
        end
      end else begin
        // [R1] Byte timer rollover
        if (timer_one == period[7:0]) begin
          next_timer_one = 8'h00;
          timer_roll = 1'b1;
        end else begin
          next_timer_one = timer_one + 8'h01;
        end
        // The second timer runs on its own period byte; no flag is set when it wraps.
        if (timer_two == period[15:8]) begin
          next_timer_two = 8'h00;
        end else begin
          next_timer_two = timer_two + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 16'h0000;
      timer_one <= 8'h00;
      timer_two <= 8'h00;
    end else begin
      tick_cnt <= next_tick_cnt;
      timer_one <= next_timer_one;
      timer_two <= next_timer_two;
    end
  end

  // ==========================================================================
  // Event capture and sticky flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_prev <= 4'h0;
      serial_q <= '{RST_TX_EMPTY, RST_RX_FULL, RST_TX_EMPTY, RST_RX_FULL};
    end else begin
      cap_prev <= {capture_four_pin, capture_three_pin, capture_two_pin, capture_one_pin};
      serial_q <= serial_status;
    end
  end

  // [R3] [R4] Capture on rising edge
  assign cap_rise = {capture_four_pin, capture_three_pin, capture_two_pin, capture_one_pin}
                    & ~cap_prev;

  always_comb begin
    set_vec[0] = timer_roll;
    set_vec[1] = cap_rise[0];
    set_vec[2] = cap_rise[1];
    set_vec[3] = cap_rise[2];
    set_vec[4] = cap_rise[3];
    // [R9] Conversion done
    set_vec[5] = converter_done_event;
    // [R13] Collision event
    set_vec[6] = bus_collision_event;
    // [R8] Sync port events
    set_vec[7] = |sync_events;
    clr_vec[0] = wr_en && (paddr == ADDR_FLAGS_ONE) && pwdata[FO_TIMER];
    clr_vec[1] = wr_en && (paddr == ADDR_FLAGS_ONE) && pwdata[FO_CAP1];
    clr_vec[2] = wr_en && (paddr == ADDR_FLAGS_ONE) && pwdata[FO_CAP2];
    clr_vec[3] = wr_en && (paddr == ADDR_FLAGS_TWO) && pwdata[FT_CAP3];
    clr_vec[4] = wr_en && (paddr == ADDR_FLAGS_TWO) && pwdata[FT_CAP4];
    clr_vec[5] = wr_en && (paddr == ADDR_FLAGS_TWO) && pwdata[FT_CONV];
    clr_vec[6] = wr_en && (paddr == ADDR_FLAGS_TWO) && pwdata[FT_BCL];
    // [R7] Only software clears it
    clr_vec[7] = wr_en && (paddr == ADDR_FLAGS_TWO) && pwdata[FT_SYNC];
  end

  for (genvar i = 0; i < 8; i++) begin : g_flag
    pfi_flag_cell #(
      .RESET_VAL(RST_FLAG)
    ) u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .set(set_vec[i]),
      .clear(clr_vec[i]),
      .flag(sticky[i])
    );
  end

  always_comb begin
    flags_one_view = 8'h00;
    flags_one_view[FO_TIMER] = sticky[0];
    flags_one_view[FO_CAP2] = sticky[2];
    flags_one_view[FO_CAP1] = sticky[1];
    // [R5] [R6] Hardware-driven levels
    flags_one_view[FO_TX1] = serial_q.one_tx_empty;
    flags_one_view[FO_RX1] = serial_q.one_rx_full;
    // [R11] [R13] Fixed order, bit four zero
    flags_two_view = 8'h00;
    flags_two_view[FT_SYNC] = sticky[7];
    flags_two_view[FT_BCL] = sticky[6];
    flags_two_view[FT_CONV] = sticky[5];
    flags_two_view[FT_CAP4] = sticky[4];
    flags_two_view[FT_CAP3] = sticky[3];
    flags_two_view[FT_TX2] = serial_q.two_tx_empty;
    // [R10] Second receive level
    flags_two_view[FT_RX2] = serial_q.two_rx_full;
  end

  // ==========================================================================
  // Interrupt output
  // [R12] Enable gates the request only
  assign next_irq = |(flags_one_view & enable_one) | |(flags_two_view & enable_two);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_byte_roll;
    ctrl[CTRL_RUN_BIT] && !ctrl[CTRL_WIDE_BIT] && tick && (timer_one == period[7:0])
    |=> (timer_one == 8'h00) && flags_one_view[FO_TIMER];
  endproperty
  a_byte_roll: assert property (p_byte_roll) else $error("Byte rollover missed."); // [R1]

  property p_wide_roll;
    ctrl[CTRL_RUN_BIT] && ctrl[CTRL_WIDE_BIT] && tick && ({timer_two, timer_one} == period)
    |=> ({timer_two, timer_one} == 16'h0000) && flags_one_view[FO_TIMER];
  endproperty
  a_wide_roll: assert property (p_wide_roll) else $error("Wide rollover missed."); // [R2]

  property p_cap_two;
    capture_two_pin && !$past(capture_two_pin) |=> flags_one_view[FO_CAP2];
  endproperty
  a_cap_two: assert property (p_cap_two) else $error("Second capture flag missed."); // [R3]

  property p_cap_one;
    !flags_one_view[FO_CAP1] && !cap_rise[0] |=> !flags_one_view[FO_CAP1];
  endproperty
  a_cap_one: assert property (p_cap_one) else $error("First capture flag set idle."); // [R4]

  // The level shows one cycle after its input, so compare with the previous sample.
  property p_tx_one;
    $past(presetn) |-> flags_one_view[FO_TX1] == $past(serial_status.one_tx_empty);
  endproperty
  a_tx_one: assert property (p_tx_one) else $error("Transmit level wrong."); // [R5]

  property p_rx_one;
    serial_status.one_rx_full ##1 serial_status.one_rx_full |=> flags_one_view[FO_RX1];
  endproperty
  a_rx_one: assert property (p_rx_one) else $error("Receive level wrong."); // [R6]

  property p_sync;
    (sync_events != 6'h00) |=> flags_two_view[FT_SYNC]
    ##1 (flags_two_view[FT_SYNC] || $past(clr_vec[7]));
  endproperty
  a_sync: assert property (p_sync) else $error("Sync flag not held."); // [R8]

  property p_conv;
    converter_done_event |=> flags_two_view[FT_CONV];
  endproperty
  a_conv: assert property (p_conv) else $error("Converter flag missed."); // [R9]

  property p_rx_two;
    !serial_status.two_rx_full |=> !flags_two_view[FT_RX2];
  endproperty
  a_rx_two: assert property (p_rx_two) else $error("Second receive wrong."); // [R10]

  property p_read_two;
    setup && !pwrite && (paddr == ADDR_FLAGS_TWO)
    |=> pready && (prdata[7:0] == $past(flags_two_view)) && !prdata[FT_UNUSED];
  endproperty
  a_read_two: assert property (p_read_two) else $error("Second flag read wrong."); // [R11]

  property p_gate;
    !enable_one[FO_TIMER] && ((flags_one_view & enable_one) == 8'h00)
    && ((flags_two_view & enable_two) == 8'h00) |=> !irq;
  endproperty
  a_gate: assert property (p_gate) else $error("Masked request raised."); // [R12]

  property p_bcl;
    bus_collision_event |=> flags_two_view[FT_BCL] && !flags_two_view[FT_UNUSED];
  endproperty
  a_bcl: assert property (p_bcl) else $error("Collision flag missed."); // [R13]

endmodule : pfi_flags

// ### testbench/test_pfi_flags.sv
// Self-checking testbench for the peripheral interrupt flag block.
module test_pfi_flags;
  timeunit 1ns;
  timeprecision 100ps;
  import pfi_pkg::*;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, bcl_ev, conv_ev;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] cap;
  pfi_sync_events_t sync_ev;
  pfi_serial_status_t ser;
  int bad_count;
  int comparisons;
  logic [32:0] exp_q[$];

  // Short tick so both timer modes finish in a few hundred cycles.
  pfi_flags #(.TICK_DIV(16'h0001)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_one_pin(cap[0]), .capture_two_pin(cap[1]),
    .capture_three_pin(cap[2]), .capture_four_pin(cap[3]), .sync_events(sync_ev),
    .bus_collision_event(bcl_ev), .converter_done_event(conv_ev), .serial_status(ser),
    .irq(irq));

  // ==========================================================================
  // Reporting
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Bus master
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The request stands until the rising edge at which pready is seen high.
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Reads are judged here, away from the driver, against the oldest note.
  always @(negedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) begin
        check("unexpected read", 33'h0, 33'h1);
      end else begin
        check($sformatf("read %h", paddr), {pslverr, prdata}, exp_q.pop_front());
      end
    end
  end

  // ==========================================================================
  // Stimulus helpers
  task automatic ev(input int k);
    @(posedge pclk);
    sync_ev <= pfi_sync_events_t'((k == 8) ? 6'h3F : (k < 6) ? 6'h01 << k : 6'h00);
    bcl_ev <= (k == 6 || k == 8);
    conv_ev <= (k >= 7);
    @(posedge pclk);
    sync_ev <= '0;
    bcl_ev <= 1'b0;
    conv_ev <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : ev

  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(negedge pclk);
      n++;
    end
  endtask : wait_irq

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] s;
    logic [7:0] a;
    int b;
    int n;
    {presetn, psel, penable, pwrite, bcl_ev, conv_ev} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cap = 4'h0;
    sync_ev = '0;
    ser = '0;
    bad_count = 0;
    comparisons = 0;
    void'($urandom(37025));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_PERIOD, {16'h0, RST_PERIOD});
    rd(ADDR_ENABLE_TWO, 32'h0);
    rd(ADDR_FLAGS_ONE, 32'h0);
    rd(ADDR_FLAGS_TWO, 32'h0);
    rd(8'h0C, 32'h0, 1'b1);
    $display("Test reset done");
    // Only the first capture is unmasked, so irq follows that flag alone.
    apb(1'b1, ADDR_ENABLE_ONE, 32'h1 << FO_CAP1);
    for (int i = 0; i < 4; i++) begin
      a = (i < 2) ? ADDR_FLAGS_ONE : ADDR_FLAGS_TWO;
      b = (i < 2) ? FO_CAP1 + i : FT_CAP3 + i - 2;
      @(posedge pclk);
      cap[i] <= 1'b1;
      repeat (3) @(negedge pclk);
      check("irq", {32'h0, irq}, {32'h0, i == 0});
      rd(a, 32'h1 << b);
      apb(1'b1, a, 32'h1 << b);
      rd(a, 32'h0);
      check("irq", {32'h0, irq}, 33'h0);
      cap[i] <= 1'b0;
    end
    apb(1'b1, ADDR_ENABLE_ONE, 32'h0);
    $display("Test captures done");
    for (int k = 0; k < 8; k++) begin
      b = (k < 6) ? FT_SYNC : (k == 6) ? FT_BCL : FT_CONV;
      ev(k);
      rd(ADDR_FLAGS_TWO, 32'h1 << b);
      rd(ADDR_FLAGS_TWO, 32'h1 << b);
      apb(1'b1, ADDR_FLAGS_TWO, 32'h1 << b);
      rd(ADDR_FLAGS_TWO, 32'h0);
    end
    ev(8);
    apb(1'b1, ADDR_FLAGS_TWO, 32'h10);
    rd(ADDR_FLAGS_TWO, 32'hE0);
    apb(1'b1, ADDR_FLAGS_TWO, 32'hFF);
    $display("Test events done");
    for (int i = 0; i < 8; i++) begin
      s = $urandom;
      ser <= pfi_serial_status_t'(s[3:0]);
      apb(1'b1, ADDR_FLAGS_ONE, 32'h3);
      rd(ADDR_FLAGS_ONE, {30'h0, s[3:2]});
      rd(ADDR_FLAGS_TWO, {30'h0, s[1:0]});
      apb(1'b1, ADDR_ENABLE_TWO, s);
      rd(ADDR_ENABLE_TWO, s & 32'hEF);
    end
    ser <= '0;
    apb(1'b1, ADDR_ENABLE_TWO, 32'h0);
    $display("Test levels done");
    apb(1'b1, ADDR_ENABLE_ONE, 32'h1 << FO_TIMER);
    apb(1'b1, ADDR_PERIOD, 32'h0003);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_RUN_BIT);
    wait_irq(n);
    check("byte wrap", {32'h0, n <= 12}, 33'h1);
    apb(1'b1, ADDR_CTRL, 32'h0);
    rd(ADDR_FLAGS_ONE, 32'h1 << FO_TIMER);
    apb(1'b1, ADDR_ENABLE_ONE, 32'h0);
    repeat (2) @(negedge pclk);
    check("irq", {32'h0, irq}, 33'h0);
    rd(ADDR_FLAGS_ONE, 32'h1 << FO_TIMER);
    apb(1'b1, ADDR_FLAGS_ONE, 32'h1 << FO_TIMER);
    apb(1'b1, ADDR_ENABLE_ONE, 32'h1 << FO_TIMER);
    // The pair must climb to 0102h; a byte compare would fire within a few ticks.
    apb(1'b1, ADDR_PERIOD, 32'h0102);
    apb(1'b1, ADDR_CTRL, (32'h1 << CTRL_RUN_BIT) | (32'h1 << CTRL_WIDE_BIT));
    wait_irq(n);
    check("wide wrap", {32'h0, n > 240 && n < 300}, 33'h1);
    apb(1'b1, ADDR_CTRL, 32'h0);
    rd(ADDR_FLAGS_ONE, 32'h1 << FO_TIMER);
    $display("Test timer done");
    n = 0;
    while (exp_q.size() > 0 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (exp_q.size() > 0) begin
      bad_count++;
    end
    finish_test();
  end
endmodule : test_pfi_flags
